/* File: include/meas_timing_map.svh */
// timing counts and fixed codes shared by the two measurement-link ends
`ifndef MEAS_TIMING_MAP_SVH
`define MEAS_TIMING_MAP_SVH

`define CLK_HZ            125000000
`define TRIG_HIGH_MIN_US  10
`define TRIG_HIGH_CYC     ((`TRIG_HIGH_MIN_US * `CLK_HZ + 999999) / 1000000)
`define TRIG_MAX_HZ       3000
`define TRIG_MAX_HZ_STD   875
`define TRIG_SPACE_CYC    ((`CLK_HZ + `TRIG_MAX_HZ - 1) / `TRIG_MAX_HZ)
`define TRIG_SPACE_STD    ((`CLK_HZ + `TRIG_MAX_HZ_STD - 1) / `TRIG_MAX_HZ_STD)
`define GATE_LOW_NS       5000
`define GATE_LOW_CYC      ((`GATE_LOW_NS * 125 + 999) / 1000)
`define SAMPLE_MAX_HZ     3000
`define SAMPLE_MIN_HZ     50
`define PERIOD_MIN_CYC    (`CLK_HZ / `SAMPLE_MAX_HZ)
`define PERIOD_MAX_CYC    (`CLK_HZ / `SAMPLE_MIN_HZ)
`define DAC_W             12
`define DAC_RESET_CODE    12'h800
`define DAC_FULL_CODE     12'hfff

`endif

/* File: include/meas_pkg.sv */
// types used by the probe end of the measurement link
package meas_pkg;
   typedef enum logic {MODE_TIME, MODE_PULSE} mode_t;
   typedef enum logic [1:0] {DAC_IDLE, DAC_DIV, DAC_LOAD} dac_state_t;
endpackage : meas_pkg

/* File: include/meas_link_if.sv */
// pins between the probe end and the stage-controller end
`timescale 1ns/1ps
`default_nettype none
interface meas_link_if;
   logic        trig;
   logic        gate;
   logic        strobe;
   logic [11:0] dac_code;

   modport dev  (input trig, output gate, output strobe, output dac_code);
   modport host (output trig, input strobe);
endinterface : meas_link_if
`default_nettype wire

/* File: rtl/meas_dev.sv */
// probe end: trigger dilution, readout gate, start strobe window, z to dac code
`timescale 1ns/1ps
`default_nettype none
`include "meas_timing_map.svh"
module meas_dev #(
   parameter logic [21:0] PERIOD_MIN = 22'(`PERIOD_MIN_CYC),
   parameter logic [21:0] PERIOD_MAX = 22'(`PERIOD_MAX_CYC)
) (
   input  wire logic          CLK_SYS_IN,
   input  wire logic          RST_B_IN,
   meas_link_if.dev           LINK,
   input  wire meas_pkg::mode_t MODE_IN,
   input  wire logic [15:0]   DILUTION_IN,
   input  wire logic [21:0]   SAMPLE_PERIOD_IN,
   input  wire logic          WIN_START_IN,
   input  wire logic          WIN_STOP_IN,
   input  wire logic [15:0]   WIN_COUNT_IN,
   input  wire logic          Z_VALID_IN,
   input  wire logic [15:0]   Z_IN,
   input  wire logic [15:0]   Z_MIN_IN,
   input  wire logic [15:0]   Z_MAX_IN,
   output logic               WINDOW_OPEN_OUT,
   output logic               MEAS_EDGE_OUT,
   output logic               DAC_BUSY_OUT
);
   localparam logic [21:0] LOW_CYC = 22'(`GATE_LOW_CYC);

   logic        trig_d_r;
   logic        trig_rise;
   logic [15:0] dil_cnt_r;
   logic        keep_trig;
   logic        pend_r;
   logic        gate_r;
   logic [21:0] gcnt_r;
   logic [21:0] period;
   logic        low_done;
   logic        high_done;
   logic        gate_up;
   logic        win_r;
   logic [16:0] rise_cnt_r;
   logic [15:0] win_count_r;
   logic        strobe_r;
   logic        edge_r;

   // clamp the sampling period into the 50..3000 Hz span
   always_comb begin
      if (SAMPLE_PERIOD_IN < PERIOD_MIN) begin
         period = PERIOD_MIN;
      end else if (SAMPLE_PERIOD_IN > PERIOD_MAX) begin
         period = PERIOD_MAX;
      end else begin
         period = SAMPLE_PERIOD_IN;
      end
   end

   assign trig_rise = LINK.trig & ~trig_d_r;
   // n of zero is taken as one so the trigger is never starved
   assign keep_trig = trig_rise && (MODE_IN == meas_pkg::MODE_PULSE) &&
                      ((dil_cnt_r + 16'h0001) >= DILUTION_IN);

   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         trig_d_r <= 1'b0;
      end else begin
         trig_d_r <= LINK.trig;
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         dil_cnt_r <= 16'h0000;
      end else if (WIN_START_IN) begin
         dil_cnt_r <= 16'h0000;
      end else if (keep_trig) begin
         dil_cnt_r <= 16'h0000;
      end else if (trig_rise && MODE_IN == meas_pkg::MODE_PULSE) begin
         dil_cnt_r <= dil_cnt_r + 16'h0001;
      end
   end

   // a kept edge during the discharge phase is held so it ends the next high phase
   assign low_done  = ~gate_r && (gcnt_r >= LOW_CYC - 22'h000001);
   assign high_done = gate_r && (pend_r || keep_trig ||
                      ((MODE_IN == meas_pkg::MODE_TIME) && (gcnt_r >= period - 22'h000001)) ||
                      (gcnt_r >= PERIOD_MAX - 22'h000001));
   assign gate_up   = low_done;

   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         pend_r <= 1'b0;
      end else if (keep_trig && !gate_r) begin
         pend_r <= 1'b1; // set wins over clear
      end else if (high_done) begin
         pend_r <= 1'b0;
      end
   end

   // gate free-runs from reset regardless of any window
   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         gate_r <= 1'b0;
         gcnt_r <= 22'h000000;
      end else if (low_done) begin
         gate_r <= 1'b1;
         gcnt_r <= 22'h000000;
      end else if (high_done) begin
         gate_r <= 1'b0;
         gcnt_r <= 22'h000000;
      end else begin
         gcnt_r <= gcnt_r + 22'h000001;
      end
   end

   // window closes one cycle after the rise that ends the last wanted measurement
   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         win_r       <= 1'b0;
         rise_cnt_r  <= 17'h00000;
         win_count_r <= 16'h0000;
      end else if (WIN_START_IN) begin
         win_r       <= 1'b1;
         rise_cnt_r  <= 17'h00000;
         win_count_r <= WIN_COUNT_IN;
      end else if (WIN_STOP_IN) begin
         win_r <= 1'b0;
      end else if (win_r && gate_up) begin
         rise_cnt_r <= rise_cnt_r + 17'h00001;
      end else if (win_r && edge_r && win_count_r != 16'h0000 && rise_cnt_r > {1'b0, win_count_r}) begin
         // held past the closing rise so a short trailing strobe shows
         win_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         strobe_r <= 1'b0;
         edge_r   <= 1'b0;
      end else begin
         strobe_r <= gate_r & win_r;
         edge_r   <= gate_up;
      end
   end

   assign LINK.gate       = gate_r;
   assign LINK.strobe     = strobe_r;
   assign WINDOW_OPEN_OUT = win_r;
   assign MEAS_EDGE_OUT   = edge_r;

   // z to dac code: (z - min) * 4095 / (max - min), 12-step restoring divide
   meas_pkg::dac_state_t dst_r;
   logic [27:0] rem_r;
   logic [15:0] den_r;
   logic [11:0] quo_r;
   logic [3:0]  bit_r;
   logic [11:0] code_r;
   logic [27:0] den_sh;

   assign den_sh = {12'h000, den_r} << bit_r;

   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         dst_r  <= meas_pkg::DAC_IDLE;
         rem_r  <= 28'h0000000;
         den_r  <= 16'h0000;
         quo_r  <= 12'h000;
         bit_r  <= 4'h0;
         code_r <= `DAC_RESET_CODE;
      end else begin
         case (dst_r)
            meas_pkg::DAC_IDLE: begin
               // new samples are dropped while a division runs
               if (Z_VALID_IN) begin
                  if (Z_IN <= Z_MIN_IN || Z_MAX_IN <= Z_MIN_IN) begin
                     code_r <= 12'h000;
                  end else if (Z_IN >= Z_MAX_IN) begin
                     code_r <= `DAC_FULL_CODE;
                  end else begin
                     rem_r <= 28'((Z_IN - Z_MIN_IN) * 28'(`DAC_FULL_CODE));
                     den_r <= Z_MAX_IN - Z_MIN_IN;
                     quo_r <= 12'h000;
                     bit_r <= 4'hb;
                     dst_r <= meas_pkg::DAC_DIV;
                  end
               end
            end
            meas_pkg::DAC_DIV: begin
               if (rem_r >= den_sh) begin
                  rem_r        <= rem_r - den_sh;
                  quo_r[bit_r] <= 1'b1;
               end
               if (bit_r == 4'h0) begin
                  dst_r <= meas_pkg::DAC_LOAD;
               end else begin
                  bit_r <= bit_r - 4'h1;
               end
            end
            meas_pkg::DAC_LOAD: begin
               code_r <= quo_r;
               dst_r  <= meas_pkg::DAC_IDLE;
            end
            default: begin
               dst_r <= meas_pkg::DAC_IDLE;
            end
         endcase
      end
   end

   logic busy_r;
   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= (dst_r != meas_pkg::DAC_IDLE) ||
                   (Z_VALID_IN && Z_IN > Z_MIN_IN && Z_IN < Z_MAX_IN);
      end
   end

   assign LINK.dac_code = code_r;
   assign DAC_BUSY_OUT  = busy_r;
endmodule : meas_dev
`default_nettype wire

/* File: rtl/meas_host.sv */
// stage-controller end: trigger generator and position latch on start strobe
`timescale 1ns/1ps
`default_nettype none
`include "meas_timing_map.svh"
module meas_host #(
   parameter logic [31:0] SPACE_MIN = 32'(`TRIG_SPACE_CYC)
) (
   input  wire logic        CLK_SYS_IN,
   input  wire logic        RST_B_IN,
   meas_link_if.host        LINK,
   input  wire logic        TRIG_EN_IN,
   input  wire logic [31:0] TRIG_PERIOD_IN,
   input  wire logic        ARM_IN,
   input  wire logic [15:0] COUNT_IN,
   input  wire logic [31:0] POSITION_IN,
   output logic [31:0]      POS_OUT,
   output logic             POS_VALID_OUT,
   output logic             DONE_OUT
);
   localparam logic [31:0] HIGH_CYC = 32'(`TRIG_HIGH_CYC);

   logic [31:0] tcnt_r;
   logic [31:0] tcnt_nxt;
   logic [31:0] tper;
   logic        trig_r;

   // spacing below the fastest rate would lose measurements
   assign tper = (TRIG_PERIOD_IN < SPACE_MIN) ? SPACE_MIN : TRIG_PERIOD_IN;
   assign tcnt_nxt = (tcnt_r >= tper - 32'h00000001) ? 32'h00000000 : tcnt_r + 32'h00000001;

   // counter parks at period end, so the first pulse after reset is as long as the rest
   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         tcnt_r <= 32'hffffffff;
         trig_r <= 1'b0;
      end else if (!TRIG_EN_IN && tcnt_r >= tper - 32'h00000001) begin
         trig_r <= 1'b0;
      end else begin
         tcnt_r <= tcnt_nxt;
         trig_r <= (tcnt_nxt < HIGH_CYC);
      end
   end

   assign LINK.trig = trig_r;

   logic        st_d_r;
   logic        st_rise;
   logic        first_r;
   logic        armed_r;
   logic [15:0] got_r;
   logic [15:0] want_r;
   logic [31:0] pos_r;
   logic        val_r;

   assign st_rise = LINK.strobe & ~st_d_r;

   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         st_d_r <= 1'b0;
      end else begin
         st_d_r <= LINK.strobe;
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         first_r <= 1'b0;
         armed_r <= 1'b0;
         got_r   <= 16'h0000;
         want_r  <= 16'h0000;
         pos_r   <= 32'h00000000;
         val_r   <= 1'b0;
      end else begin
         val_r <= 1'b0;
         if (ARM_IN) begin
            first_r <= 1'b1;
            armed_r <= 1'b1;
            got_r   <= 16'h0000;
            want_r  <= COUNT_IN;
         end else if (st_rise && armed_r) begin
            if (first_r) begin
               first_r <= 1'b0;
            end else if (want_r == 16'h0000 || got_r < want_r) begin
               pos_r <= POSITION_IN;
               val_r <= 1'b1;
               got_r <= got_r + 16'h0001;
            end
            // rises past the count are left unlatched
         end
      end
   end

   logic done_r;
   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         done_r <= 1'b0;
      end else begin
         done_r <= armed_r && !ARM_IN && want_r != 16'h0000 && got_r >= want_r;
      end
   end

   assign POS_OUT       = pos_r;
   assign POS_VALID_OUT = val_r;
   assign DONE_OUT      = done_r;
endmodule : meas_host
`default_nettype wire

/* File: dv/meas_link_props.sv */
// link assertions for the probe and controller ends
`timescale 1ns/1ps
`default_nettype none
`include "meas_timing_map.svh"
module meas_link_props #(
   parameter logic [21:0] PERIOD_MAX = 22'(`PERIOD_MAX_CYC),
   parameter logic [31:0] SPACE_MIN  = 32'(`TRIG_SPACE_CYC)
) (
   input wire logic        CLK_SYS_IN,
   input wire logic        RST_B_IN,
   input wire logic        trig,
   input wire logic        gate,
   input wire logic        strobe,
   input wire logic [11:0] dac_code
);
   logic [31:0] lo_r, hi_r, thi_r, gap_r;
   logic        fell_r;
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RST_B_IN);
   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         lo_r <= '0;
         hi_r <= '0;
         thi_r <= '0;
      end else begin
         lo_r <= gate ? '0 : lo_r + 1;
         hi_r <= gate ? hi_r + 1 : '0;
         thi_r <= trig ? thi_r + 1 : '0;
      end
   end
   // saturates so the first trigger after reset is never judged
   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) gap_r <= '1;
      else if ($rose(trig)) gap_r <= '0;
      else if (gap_r != '1) gap_r <= gap_r + 1;
   end
   // judge only low phases that follow a gate fall, not the one from reset
   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) fell_r <= 1'b0;
      else if ($fell(gate)) fell_r <= 1'b1;
   end
   sequence gate_up_s;
      $rose(gate) ##0 fell_r;
   endsequence
   sequence gate_down_s;
      $fell(gate);
   endsequence
   chk_gate_low_len: assert property (gate_up_s |-> lo_r == `GATE_LOW_CYC)
      else $error("gate low phase length wrong");
   chk_gate_keeps_cycling: assert property (lo_r <= `GATE_LOW_CYC)
      else $error("gate stuck low");
   chk_gate_high_max: assert property (hi_r <= 32'(PERIOD_MAX))
      else $error("gate high phase too long");
   chk_strobe_in_gate: assert property (strobe |-> $past(gate))
      else $error("strobe high without gate");
   chk_strobe_drops_fall: assert property (gate_down_s |=> !strobe)
      else $error("strobe outlived gate");
   chk_dac_mid_scale: assert property ($rose(RST_B_IN) |-> dac_code == `DAC_RESET_CODE)
      else $error("dac code not mid scale after reset");
   chk_trig_high_min: assert property ($fell(trig) |-> thi_r >= `TRIG_HIGH_CYC)
      else $error("trigger pulse too short");
   chk_trig_spacing: assert property ($rose(trig) |-> gap_r >= SPACE_MIN - 1)
      else $error("trigger edges too close");
endmodule : meas_link_props
`default_nettype wire

/* File: dv/test_measurement_trigger_gate_timing.sv */
// self-checking bench joining both link ends
`timescale 1ns/1ps
`default_nettype none
`include "meas_timing_map.svh"
module test_measurement_trigger_gate_timing;
   localparam logic [21:0] P_MIN = 22'h0002bc;
   localparam logic [21:0] P_MAX = 22'h004e20;
   localparam logic [31:0] SPACE = 32'h000007d0;
   localparam logic [31:0] POS   = 32'h5a5a0f0f;
   logic            clk_sys = 1'b0, rst_b = 1'b0, win_start = 1'b0, win_stop = 1'b0;
   logic            z_valid = 1'b0, arm = 1'b0, trig_en = 1'b1, ps;
   meas_pkg::mode_t mode = meas_pkg::MODE_TIME;
   logic [15:0]     dil = '0, win_cnt = 16'h0003, z = '0, z_min = 16'h0064, z_max = 16'h044c;
   logic [15:0]     count = 16'h0003;
   logic [21:0]     period = 22'h000320;
   logic            win_open, meas_edge, dac_busy, pos_valid, done;
   logic [31:0]     pos;
   int              num_errors = 0, samples_checked = 0, hi, lo, k, rises, valids, after;
   logic [15:0]     za[6] = '{16'h0258, 16'h0190, 16'h0032, 16'h044c, 16'h07d0, 16'h0258};
   logic [15:0]     zb[6] = '{16'h044c, 16'h0190, 16'h0032, 16'h044c, 16'h07d0, 16'h0258};
   meas_link_if u_meas_link_if ();
   wire logic       gt = u_meas_link_if.gate;
   wire logic       sb = u_meas_link_if.strobe;
   wire logic       tg = u_meas_link_if.trig;
   wire logic [11:0] dc = u_meas_link_if.dac_code;
   meas_dev #(.PERIOD_MIN(P_MIN), .PERIOD_MAX(P_MAX)) u_meas_dev (
      .CLK_SYS_IN(clk_sys), .RST_B_IN(rst_b), .LINK(u_meas_link_if.dev), .MODE_IN(mode), .DILUTION_IN(dil),
      .SAMPLE_PERIOD_IN(period), .WIN_START_IN(win_start), .WIN_STOP_IN(win_stop), .WIN_COUNT_IN(win_cnt),
      .Z_VALID_IN(z_valid), .Z_IN(z), .Z_MIN_IN(z_min), .Z_MAX_IN(z_max), .WINDOW_OPEN_OUT(win_open),
      .MEAS_EDGE_OUT(meas_edge), .DAC_BUSY_OUT(dac_busy));
   meas_host #(.SPACE_MIN(SPACE)) u_meas_host (
      .CLK_SYS_IN(clk_sys), .RST_B_IN(rst_b), .LINK(u_meas_link_if.host), .TRIG_EN_IN(trig_en),
      .TRIG_PERIOD_IN(SPACE), .ARM_IN(arm), .COUNT_IN(count), .POSITION_IN(POS), .POS_OUT(pos),
      .POS_VALID_OUT(pos_valid), .DONE_OUT(done));
   meas_link_props #(.PERIOD_MAX(P_MAX), .SPACE_MIN(SPACE)) u_meas_link_props (
      .CLK_SYS_IN(clk_sys), .RST_B_IN(rst_b), .trig(tg), .gate(gt), .strobe(sb), .dac_code(dc));
   always #4 clk_sys = ~clk_sys;
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic complete_run();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val
   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         num_errors++;
         complete_run();
      end
   endtask : guard
   task automatic wait_gate(input logic lvl);
      int n;
      n = 0;
      while (gt !== lvl && n < 40000) begin
         tick();
         n++;
      end
      guard(n, 40000);
   endtask : wait_gate
   // returns on the first high sample of the next phase
   task automatic gate_cycle();
      wait_gate(1'b0);
      wait_gate(1'b1);
      check_val(meas_edge, 1);
      hi = 0;
      lo = 0;
      while (gt === 1'b1 && hi < 65535) begin
         tick();
         hi++;
         if (hi == 1) check_val(meas_edge, 0);
      end
      while (gt === 1'b0 && lo < 65535) begin
         tick();
         lo++;
      end
      guard(hi + lo, 65535);
   endtask : gate_cycle
   function automatic logic [11:0] dac_exp(input logic [15:0] v, input logic [15:0] mn, input logic [15:0] mx);
      if (v <= mn || mx <= mn) return 12'h000;
      if (v >= mx) return 12'hfff;
      return 12'((32'(v - mn) * 32'h00000fff) / 32'(mx - mn));
   endfunction : dac_exp
   initial begin
      tick(10);
      check_val(dc, `DAC_RESET_CODE);
      rst_b = 1'b1;
      gate_cycle();
      check_val(hi, 32'h00000320);
      check_val(lo, `GATE_LOW_CYC);
      period = 22'h000010;
      gate_cycle();
      gate_cycle();
      check_val(hi, 32'(P_MIN));
      period = 22'h000320;
      gate_cycle();
      // open mid high phase so the extraneous first pulse shows
      tick(5);
      win_start = 1'b1;
      arm = 1'b1;
      tick();
      win_start = 1'b0;
      arm = 1'b0;
      {rises, valids, after, k, ps} = '0;
      while (after < 10 && k < 20000) begin
         tick();
         k++;
         if (sb === 1'b1 && ps === 1'b0) rises++;
         ps = sb;
         if (pos_valid === 1'b1) valids++;
         if (pos_valid === 1'b1) check_val(pos, POS);
         if (win_open === 1'b0) after++;
      end
      guard(k, 20000);
      check_val(rises, 5);
      check_val(valids, 3);
      check_val(done, 1);
      mode = meas_pkg::MODE_PULSE;
      win_cnt = '0;
      for (int i = 0; i < 3; i++) begin
         dil = (i == 2) ? 16'h0003 : 16'(i);
         wait_gate(1'b1);
         if (i == 2) begin
            // open on an unkept edge while the gate is high, so a stale count would shorten the run
            k = 0;
            ps = 1'b1;
            while (!(tg === 1'b1 && ps === 1'b0) && k < 40000) begin
               ps = tg;
               tick();
               k++;
            end
            guard(k, 40000);
         end else begin
            wait_gate(1'b0);
         end
         win_start = 1'b1;
         tick();
         win_start = 1'b0;
         {rises, hi, k} = '0;
         // a trigger pulse already high is not a new edge
         ps = tg;
         while (!(hi == 1 && gt === 1'b0) && k < 30000) begin
            tick();
            k++;
            if (tg === 1'b1 && ps === 1'b0) rises++;
            ps = tg;
            if (gt === 1'b1) hi = 1;
         end
         guard(k, 30000);
         check_val(rises, (i == 2) ? 3 : 1);
      end
      win_stop = 1'b1;
      tick();
      win_stop = 1'b0;
      check_val(win_open, 0);
      for (int i = 0; i < 6; i++) begin
         if (i == 5) z_max = z_min;
         z = za[i];
         z_valid = 1'b1;
         tick();
         check_val(dac_busy, (i < 2) ? 1 : 0);
         z = zb[i];
         tick();
         z_valid = 1'b0;
         tick(20);
         check_val(dac_busy, 0);
         check_val(dc, dac_exp(za[i], z_min, z_max));
      end
      complete_run();
   end
endmodule : test_measurement_trigger_gate_timing
`default_nettype wire
